// ===== hdl/ubc_pkg.sv
// constants and types for the baud generator and direction control block
package ubc_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [4:0]  CMD_OFF      = 5'h00;
  localparam logic [4:0]  MODE_OFF     = 5'h04;
  localparam logic [4:0]  BAUD_OFF     = 5'h08;
  localparam logic [4:0]  RATIO_OFF    = 5'h0C;
  localparam logic [4:0]  STAT_OFF     = 5'h10;

  // ==========================================================
  // command register bits
  localparam int          CMD_RX_RST   = 2;
  localparam int          CMD_TX_RST   = 3;
  localparam int          CMD_RX_ON    = 4;
  localparam int          CMD_RX_OFF   = 5;
  localparam int          CMD_TX_ON    = 6;
  localparam int          CMD_TX_OFF   = 7;

  // ==========================================================
  // mode register fields
  localparam int          MODE_LSB     = 0;
  localparam int          MODE_MSB     = 3;
  localparam int          CLKSEL_LSB   = 4;
  localparam int          CLKSEL_MSB   = 5;
  localparam int          SYNC_BIT     = 8;
  localparam int          CARD_DRV_BIT = 18;
  localparam int          OVER_BIT     = 19;

  localparam logic [3:0]  MODE_NORMAL  = 4'h0;
  localparam logic [3:0]  MODE_ISO_T0  = 4'h4;
  localparam logic [3:0]  MODE_ISO_T1  = 4'h6;
  localparam logic [3:0]  MODE_SPI_MST = 4'hE;
  localparam logic [3:0]  MODE_SPI_SLV = 4'hF;

  localparam logic [1:0]  SRC_MCK      = 2'h0;
  localparam logic [1:0]  SRC_DIV      = 2'h1;
  localparam logic [1:0]  SRC_EXT      = 2'h3;

  // ==========================================================
  // divider register fields
  localparam int          CD_LSB       = 0;
  localparam int          CD_MSB       = 15;
  localparam int          FP_LSB       = 16;
  localparam int          FP_MSB       = 18;
  localparam int          RATIO_MSB    = 10;
  localparam logic [10:0] RATIO_RST    = 11'h174;

  // ==========================================================
  // status register bits
  localparam int          ST_RX_ON     = 0;
  localparam int          ST_TX_ON     = 1;
  localparam int          ST_HOLD_FREE = 2;
  localparam int          ST_TX_DONE   = 3;
  localparam int          ST_RX_PEND   = 4;
  localparam int          ST_TX_PEND   = 5;

  // ==========================================================
  // timing counts
  localparam logic [2:0]  PRE_TOP      = 3'h7;
  localparam logic [3:0]  OVS8_TOP     = 4'h7;
  localparam logic [3:0]  OVS16_TOP    = 4'hF;

  typedef enum logic [1:0] {
    UBC_ST_OFF   = 2'h0,
    UBC_ST_ON    = 2'h1,
    UBC_ST_DRAIN = 2'h3
  } ubc_dir_state_t;

endpackage

// ===== hdl/ubc_div.sv
// divide-by-n tick generator with eighth-step fractional extension
`timescale 1ns/10ps

module ubc_div (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        src_tick_i,
  input  wire logic [15:0] div_i,
  input  wire logic [2:0]  frac_i,
  output logic             tick_o,
  output logic             level_o
);

  logic [16:0] cnt_q;
  logic [2:0]  acc_q;
  logic        extra_q;
  logic [16:0] target;
  logic [16:0] cnt_inc;
  logic        bypass;
  logic        stopped;
  logic        wrap;
  logic [3:0]  acc_sum;

  assign target  = {1'b0, div_i} + {16'h0000, extra_q};
  assign cnt_inc = cnt_q + 17'h00001;
  assign bypass  = (div_i == 16'h0001) && (frac_i == 3'h0);
  assign stopped = (div_i == 16'h0000);
  assign wrap    = (cnt_inc >= target);
  assign acc_sum = {1'b0, acc_q} + {1'b0, frac_i};

  // ==========================================================
  // period counter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 17'h00000;
    end else if (ce_i && src_tick_i) begin
      if (stopped || bypass || wrap) begin
        cnt_q <= 17'h00000;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // fraction adds one extra source tick per accumulator carry
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_q   <= 3'h0;
      extra_q <= 1'b0;
    end else if (ce_i && src_tick_i) begin
      if (stopped || bypass) begin
        acc_q   <= 3'h0;
        extra_q <= 1'b0;
      end else if (wrap) begin
        acc_q   <= acc_sum[2:0];
        extra_q <= acc_sum[3];
      end
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= src_tick_i && !stopped && (bypass || wrap);
    end
  end

  // bypass can only toggle: a flop cannot pass the clock itself
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
    end else if (ce_i && src_tick_i) begin
      if (stopped) begin
        level_o <= 1'b0;
      end else if (bypass) begin
        level_o <= !level_o;
      end else if (wrap) begin
        level_o <= 1'b1;
      end else begin
        level_o <= (cnt_inc < {1'b0, target[16:1]});
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  zero_div_stop_a: assert property (
    (ce_i && stopped) |=> !tick_o)
    else $error("divider ticked with zero divisor");

  bypass_pass_a: assert property (
    (ce_i && bypass && src_tick_i) |=> tick_o)
    else $error("divisor one did not pass source tick");

endmodule

// ===== hdl/ubc_top.sv
// baud rate generator and receiver/transmitter on-off control
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps

// What this block does
// - mode field and sync bit pick operation
// - 16-bit divisor; zero stops generator
// - divisor one with zero fraction bypasses the divider
// - source: module clock, prescaled, external pin
// - async: divide, then by 8 or 16
// - async fraction adds eighths to divisor
// - sync/SPI: divide, except external source
// - even divisor for external/prescaled duty
// - smart card: divided clock drives pin
// - card clock divided by ratio for etu
// - both off at reset; on commands
// - configuration writable while running
// - reset commands halt unless on is in the same write; clear, keep config
// - off commands request switch off
// - receiver finishes current character first
// - transmitter drains shifter and holding buffer
// - guard delay still applied while draining
// - transmitter off clears both status flags

module ubc_top (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_n_o,
  input  wire logic        rx_busy_i,
  input  wire logic        hold_empty_i,
  input  wire logic        shift_empty_i,
  input  wire logic        guard_busy_i,
  output logic             baud_tick_o,
  output logic             sample_tick_o,
  output logic             rx_enable_o,
  output logic             tx_enable_o,
  output logic             rx_reset_o,
  output logic             tx_reset_o,
  output logic             holding_free_o,
  output logic             transmit_done_o
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_ext(input logic [1:0] sel);
    return sel[1];
  endfunction

  // off wins over on, on wins over reset; reset halts without draining
  function automatic ubc_pkg::ubc_dir_state_t dir_next(
      input ubc_pkg::ubc_dir_state_t st,
      input logic wr,
      input logic on_c,
      input logic off_c,
      input logic rst_c,
      input logic busy);
    ubc_pkg::ubc_dir_state_t n;
    n = st;
    if (wr && off_c) begin
      n = (st != ubc_pkg::UBC_ST_OFF && busy && !rst_c) ?
          ubc_pkg::UBC_ST_DRAIN : ubc_pkg::UBC_ST_OFF;
    end else if (wr && on_c) begin
      n = ubc_pkg::UBC_ST_ON;
    end else if (wr && rst_c) begin
      n = ubc_pkg::UBC_ST_OFF;
    end else begin
      case (st)
        ubc_pkg::UBC_ST_DRAIN: begin
          if (!busy) begin
            n = ubc_pkg::UBC_ST_OFF;
          end
        end
        ubc_pkg::UBC_ST_ON:  n = ubc_pkg::UBC_ST_ON;
        ubc_pkg::UBC_ST_OFF: n = ubc_pkg::UBC_ST_OFF;
        default:             n = ubc_pkg::UBC_ST_OFF;
      endcase
    end
    return n;
  endfunction

  // ==========================================================
  // bus slave
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic [3:0]  mode_q;
  logic [1:0]  clksel_q;
  logic        sync_q;
  logic        card_drv_q;
  logic        over_q;
  logic [15:0] cd_q;
  logic [2:0]  fp_q;
  logic [10:0] ratio_q;
  logic [31:0] mode_img;
  logic [31:0] baud_img;
  logic [31:0] mode_new;
  logic [31:0] baud_new;
  logic [31:0] ratio_new;
  logic [31:0] stat_img;
  ubc_pkg::ubc_dir_state_t rx_st_q;
  ubc_pkg::ubc_dir_state_t tx_st_q;
  ubc_pkg::ubc_dir_state_t rx_st_d;
  ubc_pkg::ubc_dir_state_t tx_st_d;
  logic        tx_busy;

  assign req    = avs_read_i | avs_write_i;
  assign acc    = req & ~wait_q;
  assign wr_acc = acc & avs_write_i;
  assign cmd_wr = wr_acc && avs_address_i == ubc_pkg::CMD_OFF &&
                  avs_byteenable_i[0];
  assign cmd    = avs_writedata_i[7:0];

  always_comb begin
    mode_img = 32'h00000000;
    mode_img[ubc_pkg::MODE_MSB:ubc_pkg::MODE_LSB]     = mode_q;
    mode_img[ubc_pkg::CLKSEL_MSB:ubc_pkg::CLKSEL_LSB] = clksel_q;
    mode_img[ubc_pkg::SYNC_BIT]     = sync_q;
    mode_img[ubc_pkg::CARD_DRV_BIT] = card_drv_q;
    mode_img[ubc_pkg::OVER_BIT]     = over_q;
    baud_img = {13'h0000, fp_q, cd_q};
    stat_img = 32'h00000000;
    stat_img[ubc_pkg::ST_RX_ON]     = rx_enable_o;
    stat_img[ubc_pkg::ST_TX_ON]     = tx_enable_o;
    stat_img[ubc_pkg::ST_HOLD_FREE] = holding_free_o;
    stat_img[ubc_pkg::ST_TX_DONE]   = transmit_done_o;
    stat_img[ubc_pkg::ST_RX_PEND]   = (rx_st_q == ubc_pkg::UBC_ST_DRAIN);
    stat_img[ubc_pkg::ST_TX_PEND]   = (tx_st_q == ubc_pkg::UBC_ST_DRAIN);
  end

  assign mode_new  = be_merge(mode_img, avs_writedata_i, avs_byteenable_i);
  assign baud_new  = be_merge(baud_img, avs_writedata_i, avs_byteenable_i);
  assign ratio_new = be_merge({21'h000000, ratio_q}, avs_writedata_i,
                              avs_byteenable_i);

  // one wait cycle, then the answer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
    end else if (ce_i) begin
      wait_q <= ~(req & wait_q);
    end
  end
  assign avs_waitrequest_o = wait_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 32'h00000000;
    end else if (ce_i && avs_read_i && wait_q) begin
      case (avs_address_i)
        ubc_pkg::MODE_OFF:  rdata_q <= mode_img;
        ubc_pkg::BAUD_OFF:  rdata_q <= baud_img;
        ubc_pkg::RATIO_OFF: rdata_q <= {21'h000000, ratio_q};
        ubc_pkg::STAT_OFF:  rdata_q <= stat_img;
        default:            rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  // config takes writes at any time, on or off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q     <= ubc_pkg::MODE_NORMAL;
      clksel_q   <= ubc_pkg::SRC_MCK;
      sync_q     <= 1'b0;
      card_drv_q <= 1'b0;
      over_q     <= 1'b0;
    end else if (ce_i && wr_acc && avs_address_i == ubc_pkg::MODE_OFF) begin
      mode_q     <= mode_new[ubc_pkg::MODE_MSB:ubc_pkg::MODE_LSB];
      clksel_q   <= mode_new[ubc_pkg::CLKSEL_MSB:ubc_pkg::CLKSEL_LSB];
      sync_q     <= mode_new[ubc_pkg::SYNC_BIT];
      card_drv_q <= mode_new[ubc_pkg::CARD_DRV_BIT];
      over_q     <= mode_new[ubc_pkg::OVER_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cd_q    <= 16'h0000;
      fp_q    <= 3'h0;
      ratio_q <= ubc_pkg::RATIO_RST;
    end else if (ce_i && wr_acc) begin
      if (avs_address_i == ubc_pkg::BAUD_OFF) begin
        cd_q <= baud_new[ubc_pkg::CD_MSB:ubc_pkg::CD_LSB];
        fp_q <= baud_new[ubc_pkg::FP_MSB:ubc_pkg::FP_LSB];
      end
      if (avs_address_i == ubc_pkg::RATIO_OFF) begin
        ratio_q <= ratio_new[ubc_pkg::RATIO_MSB:0];
      end
    end
  end

  // ==========================================================
  // direction control
  assign tx_busy = ~hold_empty_i | ~shift_empty_i | guard_busy_i;
  assign rx_st_d = dir_next(rx_st_q, cmd_wr, cmd[ubc_pkg::CMD_RX_ON],
                            cmd[ubc_pkg::CMD_RX_OFF],
                            cmd[ubc_pkg::CMD_RX_RST], rx_busy_i);
  assign tx_st_d = dir_next(tx_st_q, cmd_wr, cmd[ubc_pkg::CMD_TX_ON],
                            cmd[ubc_pkg::CMD_TX_OFF],
                            cmd[ubc_pkg::CMD_TX_RST], tx_busy);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_st_q    <= ubc_pkg::UBC_ST_OFF;
      tx_st_q    <= ubc_pkg::UBC_ST_OFF;
      rx_reset_o <= 1'b0;
      tx_reset_o <= 1'b0;
    end else if (ce_i) begin
      rx_st_q    <= rx_st_d;
      tx_st_q    <= tx_st_d;
      rx_reset_o <= cmd_wr && cmd[ubc_pkg::CMD_RX_RST];
      tx_reset_o <= cmd_wr && cmd[ubc_pkg::CMD_TX_RST];
    end
  end
  // bit 0 of the gray state is the enable
  assign rx_enable_o = rx_st_q[0];
  assign tx_enable_o = tx_st_q[0];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      holding_free_o  <= 1'b0;
      transmit_done_o <= 1'b0;
    end else if (ce_i) begin
      if (!tx_st_d[0] || (cmd_wr && cmd[ubc_pkg::CMD_TX_RST])) begin
        holding_free_o  <= 1'b0;
        transmit_done_o <= 1'b0;
      end else begin
        holding_free_o  <= hold_empty_i;
        transmit_done_o <= hold_empty_i & shift_empty_i;
      end
    end
  end

  // ==========================================================
  // clock source
  // pin passes two synchronising stages; the third stage finds the rising edge
  logic [2:0]  pre_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        ext_s3_q;
  logic        src_tick;
  logic        is_iso;
  logic        sync_path;
  logic        cd_tick;
  logic        cd_level;
  logic        etu_tick;
  logic [3:0]  ovs_q;
  logic [3:0]  ovs_top;
  logic        ovs_wrap;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q    <= 3'h0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (ce_i) begin
      pre_q    <= pre_q + 3'h1;
      ext_s1_q <= sclk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_comb begin
    case (clksel_q)
      ubc_pkg::SRC_MCK: src_tick = 1'b1;
      ubc_pkg::SRC_DIV: src_tick = (pre_q == ubc_pkg::PRE_TOP);
      default:          src_tick = ext_s2_q & ~ext_s3_q;
    endcase
  end

  assign is_iso    = (mode_q == ubc_pkg::MODE_ISO_T0) ||
                     (mode_q == ubc_pkg::MODE_ISO_T1);
  assign sync_path = sync_q || (mode_q == ubc_pkg::MODE_SPI_MST) ||
                     (mode_q == ubc_pkg::MODE_SPI_SLV);

  ubc_div u_cd (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .src_tick_i (src_tick),
    .div_i      (cd_q),
    .frac_i     ((sync_path || is_iso) ? 3'h0 : fp_q),
    .tick_o     (cd_tick),
    .level_o    (cd_level)
  );

  ubc_div u_etu (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .src_tick_i (cd_tick),
    .div_i      ({5'h00, ratio_q}),
    .frac_i     (3'h0),
    .tick_o     (etu_tick),
    .level_o    ()
  );

  // ==========================================================
  // oversampling stage and tick outputs
  assign ovs_top  = over_q ? ubc_pkg::OVS8_TOP : ubc_pkg::OVS16_TOP;
  assign ovs_wrap = cd_tick && (ovs_q >= ovs_top);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovs_q <= 4'h0;
    end else if (ce_i && cd_tick) begin
      ovs_q <= ovs_wrap ? 4'h0 : ovs_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      baud_tick_o   <= 1'b0;
      sample_tick_o <= 1'b0;
      sclk_o        <= 1'b0;
      sclk_oe_n_o   <= 1'b1;
    end else if (ce_i) begin
      sample_tick_o <= cd_tick && !sync_path && !is_iso;
      if (is_iso) begin
        baud_tick_o <= etu_tick;
      end else if (sync_path) begin
        baud_tick_o <= is_ext(clksel_q) ? src_tick : cd_tick;
      end else begin
        baud_tick_o <= ovs_wrap;
      end
      sclk_o      <= cd_level;
      sclk_oe_n_o <= !(is_iso && card_drv_q && !is_ext(clksel_q));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_rx_off_busy;
    ce_i && cmd_wr && cmd[ubc_pkg::CMD_RX_OFF] &&
    !cmd[ubc_pkg::CMD_RX_RST] && rx_enable_o && rx_busy_i;
  endsequence

  sequence s_tx_wait;
    ce_i && tx_st_q == ubc_pkg::UBC_ST_DRAIN && tx_busy && !cmd_wr;
  endsequence

  bus_answer_a: assert property (
    (ce_i && req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");

  rx_finish_a: assert property (
    s_rx_off_busy |=> rx_enable_o ##0 rx_st_q == ubc_pkg::UBC_ST_DRAIN)
    else $error("receiver dropped during a character");

  tx_drain_a: assert property (
    s_tx_wait |=> tx_enable_o)
    else $error("transmitter off before drain");

  guard_hold_a: assert property (
    (ce_i && tx_st_q == ubc_pkg::UBC_ST_DRAIN && guard_busy_i && !cmd_wr)
    |=> tx_enable_o)
    else $error("guard delay cut short by off request");

  off_wins_a: assert property (
    (ce_i && cmd_wr && cmd[ubc_pkg::CMD_RX_ON] && cmd[ubc_pkg::CMD_RX_OFF]
     && !rx_busy_i) |=> !rx_enable_o)
    else $error("on beat off in one write");

  reset_halt_a: assert property (
    (ce_i && cmd_wr && cmd[ubc_pkg::CMD_TX_RST] &&
     !cmd[ubc_pkg::CMD_TX_ON]) |=> (!tx_enable_o && tx_reset_o &&
     !holding_free_o))
    else $error("transmit reset did not halt");

  flags_off_a: assert property (
    !tx_enable_o |-> (!holding_free_o && !transmit_done_o))
    else $error("status flag set while transmitter off");

  ovs_divide_a: assert property (
    (ce_i && cd_tick && !sync_path && !is_iso && ovs_q == ovs_top)
    |=> (baud_tick_o && ovs_q == 4'h0))
    else $error("oversampling divide wrong");

  ratio_reset_a: assert property (
    $fell(reset_i) |-> ratio_q == ubc_pkg::RATIO_RST)
    else $error("ratio reset value wrong");

endmodule

// ===== tb/ubc_peer.sv
// far-side model: external serial clock source
`timescale 1ns/10ps

module ubc_peer (
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      sclk_o
);
  // ==========================================================
  // pin clock, held low between runs
  logic [2:0] ph_q;

  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      ph_q   <= 3'h0;
      sclk_o <= 1'b0;
    end else if (ph_q == 3'h4) begin
      // five cycles a phase keeps above the 4.5x floor
      ph_q   <= 3'h0;
      sclk_o <= ~sclk_o;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end
endmodule

// ===== tb/ubc_top_test.sv
// self-checking bench for the baud generator and direction control
`timescale 1ns/10ps

module ubc_top_test;
  // ==========================================================
  // signals
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [4:0]  adr     = 5'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0;
  logic        busy    = 1'b0;
  logic        hemp    = 1'b1;
  logic        semp    = 1'b1;
  logic        guard   = 1'b0;
  logic        ext_run = 1'b0;
  logic [31:0] rdata, q;
  logic        wait_w, sclk_w, sclk_o, oe_n, bt, st;
  logic        rx_en, tx_en, rx_rst, tx_rst, hfree, tdone;
  int          err_count = 0, checked = 0, cyc = 0, nb, ns, nc;

  always #4 clk_i = ~clk_i;

  ubc_peer peer_u (.clk_i(clk_i), .run_i(ext_run), .sclk_o(sclk_w));

  ubc_top dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_n_o(oe_n),
    .rx_busy_i(busy), .hold_empty_i(hemp), .shift_empty_i(semp),
    .guard_busy_i(guard), .baud_tick_o(bt), .sample_tick_o(st),
    .rx_enable_o(rx_en), .tx_enable_o(tx_en), .rx_reset_o(rx_rst),
    .tx_reset_o(tx_rst), .holding_free_o(hfree),
    .transmit_done_o(tdone)
  );

  // ==========================================================
  // tasks
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do @(posedge clk_i); while (wait_w !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic cnt(input int n);
    nb = 0;
    ns = 0;
    nc = 0;
    repeat (n) begin
      @(posedge clk_i);
      nb += (bt === 1'b1);
      ns += (st === 1'b1);
      nc += (sclk_o === 1'b1);
    end
  endtask

  // window is a whole number of periods, so counts are exact
  task automatic gen(input logic [31:0] m, dv, input int n, b, s);
    bus(1, ubc_pkg::MODE_OFF, m);
    bus(1, ubc_pkg::BAUD_OFF, dv);
    repeat (60) @(posedge clk_i);
    cnt(n);
    chk("baud ticks", nb, b);
    chk("sample ticks", ns, s);
  endtask

  task automatic cmd(input logic [31:0] d);
    bus(1, ubc_pkg::CMD_OFF, d);
    @(posedge clk_i);
  endtask

  // ==========================================================
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, ubc_pkg::RATIO_OFF, 0);
    chk("ratio", q, 32'h0000_0174);
    bus(0, ubc_pkg::STAT_OFF, 0);
    chk("status", q, 32'h0);
    bus(0, 5'h14, 0);
    chk("unmapped", q, 32'h0);
    cnt(50);
    chk("stopped", nb, 0);
    gen(32'h0008_0000, 32'h1, 80, 10, 80);
    gen(32'h0, 32'h3, 96, 2, 32);
    gen(32'h0008_0000, 32'h0004_0002, 160, 8, 64);
    gen(32'h0000_000E, 32'h5, 100, 20, 0);
    gen(32'h0000_000F, 32'h4, 100, 25, 0);
    gen(32'h0000_0110, 32'h2, 160, 10, 0);
    ext_run <= 1'b1;
    gen(32'h0000_0130, 32'h8, 100, 10, 0);
    ext_run <= 1'b0;
    bus(1, ubc_pkg::RATIO_OFF, 32'h4);
    gen(32'h0004_0004, 32'h2, 80, 10, 0);
    chk("card clock", nc, 40);
    chk("clock drive", oe_n, 1'b0);
    gen(32'h0004_0006, 32'h2, 80, 10, 0);
    chk("card clock t1", nc, 40);
    cmd(32'h50);
    chk("rx on", rx_en, 1'b1);
    chk("tx on", tx_en, 1'b1);
    bus(1, ubc_pkg::BAUD_OFF, 32'h9);
    bus(0, ubc_pkg::BAUD_OFF, 0);
    chk("live divider", q, 32'h9);
    bus(0, ubc_pkg::STAT_OFF, 0);
    chk("status on", q, 32'hF);
    // off while a character arrives
    busy <= 1'b1;
    cmd(32'h20);
    repeat (4) @(posedge clk_i);
    chk("rx drain", rx_en, 1'b1);
    busy <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("rx off", rx_en, 1'b0);
    // off with a full pipe and guard running
    hemp  <= 1'b0;
    semp  <= 1'b0;
    guard <= 1'b1;
    cmd(32'h80);
    repeat (4) @(posedge clk_i);
    chk("tx drain", tx_en, 1'b1);
    chk("hold busy", hfree, 1'b0);
    hemp <= 1'b1;
    semp <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("guard wait", tx_en, 1'b1);
    guard <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("tx off", tx_en, 1'b0);
    chk("free flag", hfree, 1'b0);
    chk("done flag", tdone, 1'b0);
    cmd(32'hF0);
    chk("rx on+off", rx_en, 1'b0);
    chk("tx on+off", tx_en, 1'b0);
    cmd(32'h10);
    cmd(32'h04);
    chk("rx reset", rx_rst, 1'b1);
    chk("rx halted", rx_en, 1'b0);
    @(posedge clk_i);
    chk("rx reset end", rx_rst, 1'b0);
    cmd(32'h08);
    chk("tx reset", tx_rst, 1'b1);
    bus(0, ubc_pkg::BAUD_OFF, 0);
    chk("kept divider", q, 32'h9);
    // both directions off before the run ends
    chk("all off", {rx_en, tx_en}, 2'b00);
    give_verdict();
  end
endmodule
